//--- verilog/pwr_seq_pkg.sv
// Purpose: shared constants and types for the module power/reset sequencer
// Assumes: single 40 MHz clock, synchronous active-low reset
// Notes: register map and timing figures live here only
`default_nettype none

package pwr_seq_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int unsigned LAMP_FAST_MS = 100;
    localparam int unsigned LAMP_MED_MS = 500;
    localparam int unsigned LAMP_SLOW_MS = 1000;
    localparam int unsigned CORE_TIMEOUT_MS = 50;
    localparam int unsigned AUX_SETTLE_US = 100;
    localparam int CNT_W = 32;

    function automatic int unsigned ms_to_cycles(input int unsigned ms);
        return CYC_PER_MS * ms;
    endfunction

    function automatic int unsigned us_to_cycles(input int unsigned us);
        return CYC_PER_US * us;
    endfunction

    localparam int unsigned AUX_SETTLE_CYC = us_to_cycles(AUX_SETTLE_US);

    ////////////////////////////////////////////////////////////////////////////
    // register bus
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h8;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'hc;
    localparam int CTRL_HOLD_BIT = 0;
    localparam logic CTRL_HOLD_RESET = 1'h0;

    // status register layout
    localparam int ST_STATE_LSB = 0;
    localparam int ST_EXT_RST_BIT = 4;
    localparam int ST_CORE_EN_BIT = 5;
    localparam int ST_CORE_OK_BIT = 6;
    localparam int ST_XCVR_READY_BIT = 7;
    localparam int ST_DONE_BIT = 8;
    localparam int ST_PROG_SEL_BIT = 9;
    localparam int ST_MODULE_POWER_GOOD_BIT = 10;

    // interrupt layout, shared by status and mask
    localparam int IRQ_W = 4;
    localparam int IRQ_MODULE_POWER_GOOD_BIT = 0;
    localparam int IRQ_FAULT_BIT = 1;
    localparam int IRQ_EXT_RST_BIT = 2;
    localparam int IRQ_DONE_BIT = 3;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser lanes
    localparam int PIN_W = 8;
    localparam int PIN_EXT_RST_N = 0;
    localparam int PIN_CORE_EN = 1;
    localparam int PIN_CORE_OK = 2;
    localparam int PIN_XCVR_EN = 3;
    localparam int PIN_XCVR_CORE_OK = 4;
    localparam int PIN_XCVR_TERM_OK = 5;
    localparam int PIN_DONE = 6;
    localparam int PIN_PROG_SEL = 7;
    localparam logic [PIN_W-1:0] PIN_SYNC_RESET = 8'h00;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'h0,
        SEQ_CORE = 3'h1,
        SEQ_AUX = 3'h2,
        SEQ_RUN = 3'h3,
        SEQ_FAULT = 3'h4
    } seq_state_e;

    typedef enum logic [1:0] {
        LAMP_STEADY = 2'h0,
        LAMP_FAST = 2'h1,
        LAMP_MED = 2'h2,
        LAMP_SLOW = 2'h3
    } lamp_pattern_e;

endpackage

`default_nettype wire

//--- verilog/lamp_if.sv
// Purpose: carries the lamp pattern request and the lamp level
// Assumes: both ends on i_clk_sys
// Notes: no clocking block; plain wires between modules
`default_nettype none

interface lamp_if;
    import pwr_seq_pkg::*;
    lamp_pattern_e pattern;
    logic lamp;
    modport ctl (output pattern, input lamp);
    modport blink (input pattern, output lamp);
endinterface

`default_nettype wire

//--- verilog/lamp_blinker.sv
// Purpose: turns a lamp pattern into a steady or blinking lamp level
// Assumes: pattern comes from a register on the same clock
// Notes: a pattern change restarts the phase with the lamp lit
`default_nettype none

module lamp_blinker #(
    parameter int unsigned FAST_HALF_CYC = pwr_seq_pkg::ms_to_cycles(pwr_seq_pkg::LAMP_FAST_MS),
    parameter int unsigned MED_HALF_CYC = pwr_seq_pkg::ms_to_cycles(pwr_seq_pkg::LAMP_MED_MS),
    parameter int unsigned SLOW_HALF_CYC = pwr_seq_pkg::ms_to_cycles(pwr_seq_pkg::LAMP_SLOW_MS)
) (
    input wire logic i_clk_sys, // system clock
    input wire logic i_resetn,  // sync reset, active low
    lamp_if.blink lp            // pattern in, lamp out
);
    import pwr_seq_pkg::*;

    typedef struct packed {
        lamp_pattern_e pat_prev;
        logic [CNT_W-1:0] cnt;
        logic lamp;
    } blink_s;

    blink_s q;
    blink_s next_q;

    function automatic logic [CNT_W-1:0] half_last(input lamp_pattern_e p);
        unique case (p)
            LAMP_FAST: half_last = CNT_W'(FAST_HALF_CYC - 1);
            LAMP_MED: half_last = CNT_W'(MED_HALF_CYC - 1);
            LAMP_SLOW: half_last = CNT_W'(SLOW_HALF_CYC - 1);
            LAMP_STEADY: half_last = '0;
        endcase
    endfunction

    always_comb begin
        next_q = q;
        next_q.pat_prev = lp.pattern;
        if (lp.pattern == LAMP_STEADY) begin
            next_q.cnt = '0;
            next_q.lamp = 1'b1; // [R11]
        end else if (lp.pattern != q.pat_prev) begin
            next_q.cnt = '0;
            next_q.lamp = 1'b1;
        end else if (q.cnt >= half_last(lp.pattern)) begin
            next_q.cnt = '0;
            next_q.lamp = ~q.lamp; // [R10]
        end else begin
            next_q.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            q <= '{pat_prev: LAMP_STEADY, cnt: '0, lamp: 1'b1};
        end else begin
            q <= next_q;
        end
    end

    assign lp.lamp = q.lamp;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    blink_period_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [R11]
        (q.pat_prev == lp.pattern && lp.pattern != LAMP_STEADY && q.cnt == half_last(lp.pattern))
        |=> (q.lamp != $past(q.lamp)))
        else $error("lamp did not toggle at end of half period");

endmodule

`default_nettype wire

//--- verilog/module_power_reset_sequencer.sv
// Purpose: power-up and configuration-reset sequencer of the module controller
// Assumes: supply-ok, enable and reset pins are asynchronous; bus is on i_clk_sys
// Notes: lamp timing counts are top parameters so simulation can shorten them
//
// How it works
// R1: hold program line until supplies sequenced
// R2: external reset low reasserts program line
// R3: no sequence start while core enable low
// R4: switch aux rail only after core stable
// R5: power good only when all supplies stable
// R6: carrier keeps I/Os tri-stated until power good
// R7: FPGA drives transceiver supply enable before use
// R8: transceivers ready only with both supply oks
// R9: program select high for reprogramming only
// R10: status lamp flashes to show board state
// R11: steady, 0.1s, 0.5s, 1s lamp patterns
// R12: supply drop drops power good, reasserts reset
//
// Local design decisions: the address map and the plain strobed port.
`default_nettype none

module module_power_reset_sequencer #(
    parameter int unsigned CORE_TIMEOUT_CYC =
        pwr_seq_pkg::ms_to_cycles(pwr_seq_pkg::CORE_TIMEOUT_MS),
    parameter int unsigned FAST_HALF_CYC = pwr_seq_pkg::ms_to_cycles(pwr_seq_pkg::LAMP_FAST_MS),
    parameter int unsigned MED_HALF_CYC = pwr_seq_pkg::ms_to_cycles(pwr_seq_pkg::LAMP_MED_MS),
    parameter int unsigned SLOW_HALF_CYC = pwr_seq_pkg::ms_to_cycles(pwr_seq_pkg::LAMP_SLOW_MS)
) (
    input wire logic i_clk_sys,                            // 40 MHz clock
    input wire logic i_resetn,                             // sync reset, active low
    input wire logic i_external_reset_in_n,                // pin, active low
    input wire logic i_core_supply_enable,                 // pin, start sequence
    input wire logic i_core_supply_ok,                     // pin, core rail stable
    input wire logic i_xcvr_supply_enable,                 // pin, from FPGA logic
    input wire logic i_xcvr_core_supply_ok,                // pin, xcvr core ok
    input wire logic i_xcvr_term_supply_ok,                // pin, xcvr term ok
    input wire logic i_config_done,                        // pin, FPGA configured
    input wire logic i_controller_program_select,          // pin, reprogram mode
    input wire logic [pwr_seq_pkg::ADDR_W-1:0] i_addr,     // register address
    input wire logic [pwr_seq_pkg::DATA_W-1:0] i_wr_data,  // write data
    input wire logic i_wr,                                 // write strobe
    input wire logic i_rd,                                 // read strobe
    output logic [pwr_seq_pkg::DATA_W-1:0] o_rd_data,      // read data, next cycle
    output logic o_core_regulator_enable,                  // core regulators on
    output logic o_aux_rail_switch,                        // aux rail to internal rail
    output logic o_config_program_line_n,                  // low holds FPGA in reset
    output logic o_module_power_good,                      // to carrier board
    output logic o_xcvr_ready,                             // transceivers usable
    output logic o_status_lamp,                            // status lamp drive
    output logic o_irq                                     // level interrupt
);
    import pwr_seq_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [PIN_W-1:0] sync1;
        logic [PIN_W-1:0] sync2;
        seq_state_e state;
        logic [CNT_W-1:0] cnt;
        logic core_reg_en;
        logic aux_switch;
        logic module_power_good;
        logic prog_n;
        logic xcvr_ready;
        logic done_prev;
        logic ext_prev;
        lamp_pattern_e lamp_pat;
        logic ctrl_hold;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic [DATA_W-1:0] rd_data;
    } seq_s;

    seq_s q;
    seq_s next_q;

    lamp_if lp ();

    logic ext_ok;
    logic core_en;
    logic core_ok;
    logic xcvr_ok;
    logic done;

    // only the second synchroniser stage is looked at
    assign ext_ok = q.sync2[PIN_EXT_RST_N];
    assign core_en = q.sync2[PIN_CORE_EN];
    assign core_ok = q.sync2[PIN_CORE_OK];
    assign xcvr_ok = q.sync2[PIN_XCVR_EN] & q.sync2[PIN_XCVR_CORE_OK]
                   & q.sync2[PIN_XCVR_TERM_OK];
    assign done = q.sync2[PIN_DONE];

    function automatic logic [DATA_W-1:0] status_word(input seq_s s);
        logic [DATA_W-1:0] w;
        w = '0;
        w[ST_STATE_LSB +: 3] = s.state;
        w[ST_EXT_RST_BIT] = s.sync2[PIN_EXT_RST_N];
        w[ST_CORE_EN_BIT] = s.sync2[PIN_CORE_EN];
        w[ST_CORE_OK_BIT] = s.sync2[PIN_CORE_OK];
        w[ST_XCVR_READY_BIT] = s.xcvr_ready;
        w[ST_DONE_BIT] = s.sync2[PIN_DONE];
        w[ST_PROG_SEL_BIT] = s.sync2[PIN_PROG_SEL]; // [R9]
        w[ST_MODULE_POWER_GOOD_BIT] = s.module_power_good;
        return w;
    endfunction

    always_comb begin
        logic [IRQ_W-1:0] events;
        logic [IRQ_W-1:0] clr;
        next_q = q;
        events = '0;
        clr = '0;
        next_q.sync1 = {i_controller_program_select, i_config_done, i_xcvr_term_supply_ok,
                        i_xcvr_core_supply_ok, i_xcvr_supply_enable, i_core_supply_ok,
                        i_core_supply_enable, i_external_reset_in_n};
        next_q.sync2 = q.sync1;

        ////////////////////////////////////////////////////////////////////////
        // sequence
        unique case (q.state)
            SEQ_IDLE: begin
                if (core_en) begin
                    next_q.state = SEQ_CORE; // [R3]
                    next_q.cnt = '0;
                end
            end
            SEQ_CORE: begin
                if (core_ok) begin
                    next_q.state = SEQ_AUX; // [R4]
                    next_q.cnt = '0;
                end else if (q.cnt >= CNT_W'(CORE_TIMEOUT_CYC - 1)) begin
                    next_q.state = SEQ_FAULT;
                end else begin
                    next_q.cnt = q.cnt + 1'b1;
                end
            end
            SEQ_AUX: begin
                // let the aux rail settle before declaring power good
                if (!core_ok) begin
                    next_q.state = SEQ_FAULT;
                end else if (q.cnt >= CNT_W'(AUX_SETTLE_CYC - 1)) begin
                    next_q.state = SEQ_RUN; // [R5]
                end else begin
                    next_q.cnt = q.cnt + 1'b1;
                end
            end
            SEQ_RUN: begin
                if (!core_ok) begin
                    next_q.state = SEQ_FAULT; // [R12]
                end
            end
            SEQ_FAULT: begin
                // recovery re-runs the aux settle, never jumps straight to run
                if (core_ok) begin
                    next_q.state = SEQ_AUX; // [R12]
                    next_q.cnt = '0;
                end
            end
            default: begin
                next_q.state = SEQ_IDLE;
            end
        endcase
        if (!core_en) begin
            next_q.state = SEQ_IDLE; // [R3]
            next_q.cnt = '0;
        end

        next_q.core_reg_en = (next_q.state != SEQ_IDLE);
        next_q.aux_switch = (next_q.state == SEQ_AUX) || (next_q.state == SEQ_RUN); // [R4]
        next_q.module_power_good = (next_q.state == SEQ_RUN); // [R5]
        next_q.prog_n = next_q.module_power_good && ext_ok && !q.ctrl_hold; // [R1] [R2]
        next_q.xcvr_ready = xcvr_ok && next_q.module_power_good; // [R8]

        ////////////////////////////////////////////////////////////////////////
        // lamp pattern
        if (!ext_ok) begin
            next_q.lamp_pat = LAMP_STEADY; // [R11]
        end else if (!q.module_power_good) begin
            next_q.lamp_pat = LAMP_FAST;
        end else if (!done) begin
            next_q.lamp_pat = LAMP_MED;
        end else begin
            next_q.lamp_pat = LAMP_SLOW; // [R10]
        end

        ////////////////////////////////////////////////////////////////////////
        // events and register bus
        next_q.done_prev = done;
        next_q.ext_prev = ext_ok;
        events[IRQ_MODULE_POWER_GOOD_BIT] = next_q.module_power_good && !q.module_power_good;
        events[IRQ_FAULT_BIT] = (next_q.state == SEQ_FAULT) && (q.state != SEQ_FAULT);
        events[IRQ_EXT_RST_BIT] = q.ext_prev && !ext_ok;
        events[IRQ_DONE_BIT] = done && !q.done_prev;

        next_q.rd_data = '0;
        if (i_rd) begin
            unique case (i_addr)
                REG_CTRL: next_q.rd_data[CTRL_HOLD_BIT] = q.ctrl_hold;
                REG_STATUS: next_q.rd_data = status_word(q);
                REG_IRQ_STAT: begin
                    next_q.rd_data[IRQ_W-1:0] = q.irq_stat;
                    clr = q.irq_stat;
                end
                REG_IRQ_MASK: next_q.rd_data[IRQ_W-1:0] = q.irq_mask;
                default: next_q.rd_data = '0;
            endcase
        end
        if (i_wr) begin
            unique case (i_addr)
                REG_CTRL: next_q.ctrl_hold = i_wr_data[CTRL_HOLD_BIT];
                REG_IRQ_MASK: next_q.irq_mask = i_wr_data[IRQ_W-1:0];
                default: ;
            endcase
        end
        // a new event in the clearing read's cycle stays set
        next_q.irq_stat = (q.irq_stat & ~clr) | events;
        next_q.irq = |(next_q.irq_stat & next_q.irq_mask);
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            q <= '{sync1: PIN_SYNC_RESET, sync2: PIN_SYNC_RESET, state: SEQ_IDLE, cnt: '0,
                   core_reg_en: 1'b0, aux_switch: 1'b0, module_power_good: 1'b0, prog_n: 1'b0,
                   xcvr_ready: 1'b0, done_prev: 1'b0, ext_prev: 1'b0,
                   lamp_pat: LAMP_STEADY, ctrl_hold: CTRL_HOLD_RESET, irq_stat: '0,
                   irq_mask: IRQ_MASK_RESET, irq: 1'b0, rd_data: '0};
        end else begin
            q <= next_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // lamp and outputs
    assign lp.pattern = q.lamp_pat;

    lamp_blinker #(
        .FAST_HALF_CYC(FAST_HALF_CYC),
        .MED_HALF_CYC(MED_HALF_CYC),
        .SLOW_HALF_CYC(SLOW_HALF_CYC)
    ) u_blinker (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .lp(lp.blink)
    );

    assign o_rd_data = q.rd_data;
    assign o_core_regulator_enable = q.core_reg_en;
    assign o_aux_rail_switch = q.aux_switch;
    assign o_config_program_line_n = q.prog_n;
    assign o_module_power_good = q.module_power_good; // [R6]
    assign o_xcvr_ready = q.xcvr_ready; // [R7]
    assign o_status_lamp = lp.lamp;
    assign o_irq = q.irq;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);

    config_hold_a: assert property ( // [R1]
        !o_module_power_good |-> !o_config_program_line_n)
        else $error("program line released before power good");

    ext_reset_a: assert property ( // [R2]
        !ext_ok |=> !o_config_program_line_n)
        else $error("external reset did not reassert program line");

    enable_gate_a: assert property ( // [R3]
        !core_en |=> (q.state == SEQ_IDLE) && !o_core_regulator_enable)
        else $error("sequence started while core enable low");

    aux_after_core_a: assert property ( // [R4]
        $rose(o_aux_rail_switch) |-> $past(core_ok))
        else $error("aux rail switched before core stable");

    module_power_good_settle_a: assert property ( // [R5]
        $rose(o_module_power_good) |-> $past(o_aux_rail_switch) && $past(core_ok))
        else $error("power good raised without settled supplies");

    xcvr_ready_a: assert property ( // [R8]
        o_xcvr_ready |-> $past(q.sync2[PIN_XCVR_CORE_OK] && q.sync2[PIN_XCVR_TERM_OK]))
        else $error("transceiver ready without both supply oks");

    lamp_steady_a: assert property ( // [R11]
        !ext_ok ##1 !ext_ok |=> o_status_lamp)
        else $error("lamp not steady under external reset");

    supply_drop_a: assert property ( // [R12]
        (q.state == SEQ_RUN) && !core_ok && core_en
        |=> !o_module_power_good && !o_config_program_line_n && !o_aux_rail_switch
        ##1 (!o_aux_rail_switch || $past(core_ok))[*2])
        else $error("supply drop did not remove power good");

    irq_level_a: assert property (
        (|(q.irq_stat & q.irq_mask)) |-> o_irq)
        else $error("interrupt low with unmasked status set");

    module_power_good_seen_c: cover property ($rose(o_module_power_good));
    fault_seen_c: cover property ((q.state == SEQ_RUN) ##1 (q.state == SEQ_FAULT));
    recover_seen_c: cover property ((q.state == SEQ_FAULT) ##1 (q.state == SEQ_AUX));
    ext_reset_c: cover property (o_module_power_good && !ext_ok ##1 !o_config_program_line_n);

endmodule

`default_nettype wire

//--- tb/carrier_fpga_model.sv
// Purpose: regulators and FPGA that sit around the sequencer
// Assumes: tb commands the regulator mode and any brown-out
// Notes: a supply that is switched off reads low from the next clock edge
`default_nettype none

module carrier_fpga_model #(
    parameter int DONE_DLY = 100
) (
    input wire logic i_clk_sys,               // clock
    input wire logic i_core_regulator_enable, // core regulators on
    input wire logic i_config_program_line_n, // low holds config reset
    input wire logic i_xcvr_supply_enable,    // from fpga logic
    input wire logic [1:0] i_mode,            // 0 prompt, 1 slow, 2 dead
    input wire logic i_drop,                  // forced brown-out
    output logic o_core_supply_ok,            // core rail stable
    output logic o_xcvr_core_supply_ok,       // xcvr core ok
    output logic o_xcvr_term_supply_ok,       // xcvr term ok
    output logic o_config_done                // fpga configured
);
    timeunit 1ns;
    timeprecision 1ps;
    int core_cnt = 0;
    int xc_cnt = 0;
    int done_cnt = 0;

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        o_core_supply_ok = 1'b0;
        o_xcvr_core_supply_ok = 1'b0;
        o_xcvr_term_supply_ok = 1'b0;
        o_config_done = 1'b0;
    end

    always @(posedge i_clk_sys) begin
        core_cnt <= i_core_regulator_enable ? core_cnt + 1 : 0;
        xc_cnt <= i_xcvr_supply_enable ? xc_cnt + 1 : 0;
        done_cnt <= i_config_program_line_n ? done_cnt + 1 : 0;
        // dead mode never settles, so the sequencer must time out
        o_core_supply_ok <= i_core_regulator_enable && !i_drop && i_mode != 2'h2
            && core_cnt >= (i_mode == 2'h1 ? 30 : 5);
        // term rail slower on purpose: ready must wait for both
        o_xcvr_core_supply_ok <= i_xcvr_supply_enable && xc_cnt >= 6;
        o_xcvr_term_supply_ok <= i_xcvr_supply_enable && xc_cnt >= 12;
        o_config_done <= i_config_program_line_n && done_cnt >= DONE_DLY;
    end
endmodule

`default_nettype wire

//--- tb/tb.sv
// Purpose: self-checking bench of the power/reset sequencer
// Assumes: shortened lamp and timeout counts, settle count as built
// Notes: outputs sampled 1 ns after the edge
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pwr_seq_pkg::*;
    localparam int T_FAST = 4;
    localparam int T_MED = 8;
    localparam int T_SLOW = 12;
    localparam int T_CORE = 50;
    localparam int CRE = 0, AUX = 1, PRG = 2, PG = 3, XR = 4, LMP = 5, IRQ = 6;
    logic i_clk_sys, i_resetn, ext_n, core_en, core_ok, xen, xc_ok, xt_ok, done, psel;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wr_data, o_rd_data, d;
    logic i_wr, i_rd, i_drop;
    logic [1:0] i_mode;
    logic cre, aux, prg, pg, xr, lamp, irq;
    logic [6:0] outs;
    int fail_count = 0;
    int cmp_count = 0;
    int n;
    assign outs = {irq, lamp, xr, pg, prg, aux, cre};

    module_power_reset_sequencer #(
        .CORE_TIMEOUT_CYC(T_CORE), .FAST_HALF_CYC(T_FAST),
        .MED_HALF_CYC(T_MED), .SLOW_HALF_CYC(T_SLOW)
    ) DUT (
        .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_external_reset_in_n(ext_n),
        .i_core_supply_enable(core_en), .i_core_supply_ok(core_ok),
        .i_xcvr_supply_enable(xen), .i_xcvr_core_supply_ok(xc_ok),
        .i_xcvr_term_supply_ok(xt_ok), .i_config_done(done),
        .i_controller_program_select(psel), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .o_core_regulator_enable(cre),
        .o_aux_rail_switch(aux), .o_config_program_line_n(prg),
        .o_module_power_good(pg), .o_xcvr_ready(xr), .o_status_lamp(lamp), .o_irq(irq)
    );

    carrier_fpga_model partner (
        .i_clk_sys(i_clk_sys), .i_core_regulator_enable(cre),
        .i_config_program_line_n(prg), .i_xcvr_supply_enable(xen), .i_mode(i_mode),
        .i_drop(i_drop), .o_core_supply_ok(core_ok), .o_xcvr_core_supply_ok(xc_ok),
        .o_xcvr_term_supply_ok(xt_ok), .o_config_done(done)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wr_data <= v;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        v = o_rd_data;
    endtask

    task automatic wait_for(input int b, input logic v, input int lim, output int c);
        c = 0;
        while (outs[b] !== v && c < lim) begin
            @(posedge i_clk_sys);
            #1;
            c++;
        end
    endtask

    // first toggle aligns the phase, second one is measured
    task automatic lamp_half(output int c);
        int dummy;
        wait_for(LMP, !outs[LMP], 100, dummy);
        wait_for(LMP, !outs[LMP], 100, c);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end

    initial begin
        repeat (60000) @(posedge i_clk_sys);
        fail_count++;
        wrap_up();
    end

    initial begin
        i_resetn = 1'b0;
        ext_n = 1'b1;
        core_en = 1'b0;
        xen = 1'b0;
        psel = 1'b0;
        i_addr = '0;
        i_wr_data = '0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_mode = 2'h0;
        i_drop = 1'b0;
        repeat (5) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        @(posedge i_clk_sys);
        #1;
        chk("reset outputs", outs, 7'h20);
        rd(REG_CTRL, d);
        chk("ctrl reset", d, 32'h0);
        rd(REG_IRQ_MASK, d);
        chk("mask reset", d, 32'(IRQ_MASK_RESET));
        rd(4'h2, d);
        chk("unmapped", d, 32'h0);
        wr(REG_IRQ_MASK, 32'h0000_000f);
        repeat (40) @(posedge i_clk_sys);
        #1;
        chk("held idle", outs[CRE], 1'b0);
        chk("prog idle", outs[PRG], 1'b0);
        // dead core rail: sequencer must time out into fault
        @(posedge i_clk_sys);
        i_mode <= 2'h2;
        core_en <= 1'b1;
        wait_for(CRE, 1'b1, 5, n);
        chk("core start", outs[CRE], 1'b1);
        lamp_half(n);
        chk("fast lamp", n, T_FAST);
        wait_for(IRQ, 1'b1, T_CORE + 20, n);
        chk("fault irq", outs[IRQ], 1'b1);
        rd(REG_STATUS, d);
        chk("fault state", d, 32'h34);
        chk("aux in fault", outs[AUX], 1'b0);
        rd(REG_IRQ_STAT, d);
        chk("fault stat", d, 32'h2);
        chk("irq cleared", outs[IRQ], 1'b0);
        @(posedge i_clk_sys);
        i_mode <= 2'h1;
        wait_for(AUX, 1'b1, 60, n);
        chk("aux on", outs[AUX], 1'b1);
        chk("pg early", outs[PG], 1'b0);
        chk("prog early", outs[PRG], 1'b0);
        wait_for(PG, 1'b1, 4100, n);
        chk("settle", n, AUX_SETTLE_CYC);
        chk("prog released", outs[PRG], 1'b1);
        repeat (2) @(posedge i_clk_sys);
        #1;
        lamp_half(n);
        chk("med lamp", n, T_MED);
        repeat (100) @(posedge i_clk_sys);
        lamp_half(n);
        chk("slow lamp", n, T_SLOW);
        rd(REG_IRQ_STAT, d);
        chk("run stat", d, 32'h9);
        @(posedge i_clk_sys);
        xen <= 1'b1;
        wait_for(XR, 1'b1, 40, n);
        chk("xcvr late", 32'(n > 12), 32'h1);
        chk("xcvr ready", outs[XR], 1'b1);
        @(posedge i_clk_sys);
        psel <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        rd(REG_STATUS, d);
        chk("run status", d, 32'h7f3);
        @(posedge i_clk_sys);
        psel <= 1'b0;
        wr(REG_IRQ_MASK, 32'h0);
        @(posedge i_clk_sys);
        ext_n <= 1'b0;
        wait_for(PRG, 1'b0, 5, n);
        chk("ext reset prog", outs[PRG], 1'b0);
        repeat (4) @(posedge i_clk_sys);
        #1;
        wait_for(LMP, 1'b0, 30, n);
        chk("steady lamp", n, 30);
        chk("masked irq", outs[IRQ], 1'b0);
        rd(REG_IRQ_STAT, d);
        chk("ext stat", d, 32'h4);
        @(posedge i_clk_sys);
        ext_n <= 1'b1;
        wait_for(PRG, 1'b1, 5, n);
        chk("ext release", outs[PRG], 1'b1);
        wr(REG_CTRL, 32'h1);
        wait_for(PRG, 1'b0, 3, n);
        chk("hold prog", outs[PRG], 1'b0);
        wr(REG_CTRL, 32'h0);
        wait_for(PRG, 1'b1, 3, n);
        chk("unhold prog", outs[PRG], 1'b1);
        // brown-out in run, then recovery
        @(posedge i_clk_sys);
        i_drop <= 1'b1;
        wait_for(PG, 1'b0, 6, n);
        chk("drop pg", outs[PG], 1'b0);
        chk("drop prog", outs[PRG], 1'b0);
        repeat (2) @(posedge i_clk_sys);
        #1;
        lamp_half(n);
        chk("drop lamp", n, T_FAST);
        @(posedge i_clk_sys);
        i_drop <= 1'b0;
        wait_for(PG, 1'b1, 4100, n);
        chk("recover pg", outs[PG], 1'b1);
        @(posedge i_clk_sys);
        core_en <= 1'b0;
        wait_for(CRE, 1'b0, 6, n);
        chk("enable off", outs[CRE], 1'b0);
        chk("off pg", outs[PG], 1'b0);
        wrap_up();
    end
endmodule

`default_nettype wire
